// [verilog/ldm_pkg.sv]
// Package with register map, field layout and reset values for the bank
package ldm_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int DC_W = 14;
  // Register offsets
  localparam logic [9:0] OVERRANGE_DETECT_CONTROL = 10'h104;
  localparam logic [9:0] COARSE_HIGH_LIMIT = 10'h105;
  localparam logic [9:0] FINE_HIGH_LIMIT_LOW = 10'h106;
  localparam logic [9:0] FINE_HIGH_LIMIT_HIGH = 10'h107;
  localparam logic [9:0] FINE_LOW_LIMIT_LOW = 10'h108;
  localparam logic [9:0] FINE_LOW_LIMIT_HIGH = 10'h109;
  localparam logic [9:0] GAIN_UP_DWELL_LOW = 10'h10a;
  localparam logic [9:0] GAIN_UP_DWELL_HIGH = 10'h10b;
  localparam logic [9:0] OFFSET_CORRECTION_CONTROL = 10'h10c;
  localparam logic [9:0] CHAN_A_OFFSET_LOW = 10'h10d;
  localparam logic [9:0] CHAN_A_OFFSET_HIGH = 10'h10e;
  localparam logic [9:0] CHAN_B_OFFSET_LOW = 10'h10f;
  localparam logic [9:0] CHAN_B_OFFSET_HIGH = 10'h110;
  localparam logic [9:0] MONITOR_SERIAL_OUT_CONTROL = 10'h111;
  // Writable field masks (open bits read zero)
  localparam logic [7:0] DETECT_CTRL_MASK = 8'h0f;
  localparam logic [7:0] COARSE_MASK = 8'h07;
  localparam logic [7:0] FINE_HIGH_MASK = 8'h1f;
  localparam logic [7:0] CORR_CTRL_MASK = 8'h7f;
  localparam logic [7:0] SERIAL_CTRL_MASK = 8'h7f;
  localparam logic [7:0] DC_HIGH_MASK = 8'h3f;
  // Reset values
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] SERIAL_CTRL_RESET = 8'h04;
  // Field positions
  localparam int DET_EN_BIT = 0;
  localparam int DET_MODE_LSB = 1;
  localparam int CORR_PATH_EN_BIT = 0;
  localparam int CORR_MON_EN_BIT = 1;
  localparam int CORR_BW_LSB = 2;
  localparam int CORR_FREEZE_BIT = 6;
  localparam int SER_OUT_EN_BIT = 0;
  localparam int SER_SLEEP_BIT = 1;
  localparam int SER_DIV_LSB = 2;
  localparam int SER_THR_EN_BIT = 4;
  localparam int SER_PEAK_EN_BIT = 5;
  localparam int SER_RMS_EN_BIT = 6;
endpackage

// [verilog/ldm_regs.sv]
// Overrange detect and DC monitor register bank, two channels
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module ldm_regs #(
  parameter int ADDR_W = ldm_pkg::ADDR_W,
  parameter int DC_W = ldm_pkg::DC_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic chan_sel,
  output logic [7:0] rdata,
  // DC estimates from the monitor datapath, same clock
  input wire logic [DC_W-1:0] dc_est_a,
  input wire logic [DC_W-1:0] dc_est_b,
  // Overrange detect settings of both channels, {B, A}
  output logic [1:0] detect_enable,
  output logic [5:0] detect_mode,
  output logic [5:0] coarse_limit,
  output logic [25:0] fine_high_limit,
  output logic [25:0] fine_low_limit,
  output logic [31:0] gain_up_dwell,
  // Shared DC correction controls
  output logic [3:0] corr_bandwidth,
  output logic corr_path_enable,
  output logic corr_monitor_enable,
  output logic corr_freeze,
  // Monitor serial output port controls
  output logic serial_out_enable,
  output logic serial_clock_sleep,
  output logic [1:0] serial_clock_div,
  output logic serial_thresh_enable,
  output logic serial_peak_enable,
  output logic serial_rms_enable
);

  // Per-channel local registers; index 0 is channel A, 1 is channel B
  logic [7:0] det_ctrl [2];
  logic [7:0] coarse [2];
  logic [7:0] fine_hi_l [2];
  logic [7:0] fine_hi_h [2];
  logic [7:0] fine_lo_l [2];
  logic [7:0] fine_lo_h [2];
  logic [7:0] dwell_l [2];
  logic [7:0] dwell_h [2];
  // Global registers
  logic [7:0] corr_ctrl;
  logic [7:0] ser_ctrl;
  logic [7:0] next_rdata;
  // One-hot address selects; register selects drive the write path, estimate selects the read mux
  logic sel_det;
  logic sel_coarse;
  logic sel_fhi_l;
  logic sel_fhi_h;
  logic sel_flo_l;
  logic sel_flo_h;
  logic sel_dwell_l;
  logic sel_dwell_h;
  logic sel_corr;
  logic sel_ser;
  logic sel_dca_l;
  logic sel_dca_h;
  logic sel_dcb_l;
  logic sel_dcb_h;

  // True when addr hits the given offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [9:0] off);
    hit = (a == off);
  endfunction

  // Address decode; full 10-bit match so aliases never alias
  always_comb begin
    sel_det = hit(addr, ldm_pkg::OVERRANGE_DETECT_CONTROL);
    sel_coarse = hit(addr, ldm_pkg::COARSE_HIGH_LIMIT);
    sel_fhi_l = hit(addr, ldm_pkg::FINE_HIGH_LIMIT_LOW);
    sel_fhi_h = hit(addr, ldm_pkg::FINE_HIGH_LIMIT_HIGH);
    sel_flo_l = hit(addr, ldm_pkg::FINE_LOW_LIMIT_LOW);
    sel_flo_h = hit(addr, ldm_pkg::FINE_LOW_LIMIT_HIGH);
    sel_dwell_l = hit(addr, ldm_pkg::GAIN_UP_DWELL_LOW);
    sel_dwell_h = hit(addr, ldm_pkg::GAIN_UP_DWELL_HIGH);
    sel_corr = hit(addr, ldm_pkg::OFFSET_CORRECTION_CONTROL);
    sel_ser = hit(addr, ldm_pkg::MONITOR_SERIAL_OUT_CONTROL);
    // Estimate selects feed the read mux only
    sel_dca_l = hit(addr, ldm_pkg::CHAN_A_OFFSET_LOW);
    sel_dca_h = hit(addr, ldm_pkg::CHAN_A_OFFSET_HIGH);
    sel_dcb_l = hit(addr, ldm_pkg::CHAN_B_OFFSET_LOW);
    sel_dcb_h = hit(addr, ldm_pkg::CHAN_B_OFFSET_HIGH);
  end

  // Detect control and coarse limit of the channel picked by chan_sel
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 2; i++) begin
        det_ctrl[i] <= ldm_pkg::RESET_ZERO;
        coarse[i] <= ldm_pkg::RESET_ZERO;
      end
    end else if (wr) begin
      if (sel_det) begin
        det_ctrl[chan_sel] <= wdata & ldm_pkg::DETECT_CTRL_MASK;
      end
      if (sel_coarse) begin
        coarse[chan_sel] <= wdata & ldm_pkg::COARSE_MASK;
      end
    end
  end

  // Fine upper limit bytes; open bits masked so they read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 2; i++) begin
        fine_hi_l[i] <= ldm_pkg::RESET_ZERO;
        fine_hi_h[i] <= ldm_pkg::RESET_ZERO;
      end
    end else if (wr) begin
      if (sel_fhi_l) begin
        fine_hi_l[chan_sel] <= wdata;
      end
      if (sel_fhi_h) begin
        fine_hi_h[chan_sel] <= wdata & ldm_pkg::FINE_HIGH_MASK;
      end
    end
  end

  // Fine lower limit bytes, same layout as the upper limit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 2; i++) begin
        fine_lo_l[i] <= ldm_pkg::RESET_ZERO;
        fine_lo_h[i] <= ldm_pkg::RESET_ZERO;
      end
    end else if (wr) begin
      if (sel_flo_l) begin
        fine_lo_l[chan_sel] <= wdata;
      end
      if (sel_flo_h) begin
        fine_lo_h[chan_sel] <= wdata & ldm_pkg::FINE_HIGH_MASK;
      end
    end
  end

  // Dwell bytes; no latch, so a half-written count is seen briefly
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 2; i++) begin
        dwell_l[i] <= ldm_pkg::RESET_ZERO;
        dwell_h[i] <= ldm_pkg::RESET_ZERO;
      end
    end else if (wr) begin
      if (sel_dwell_l) begin
        dwell_l[chan_sel] <= wdata;
      end
      if (sel_dwell_h) begin
        dwell_h[chan_sel] <= wdata;
      end
    end
  end

  // Correction control; estimate offsets have no write path
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      corr_ctrl <= ldm_pkg::RESET_ZERO;
    end else if (wr && sel_corr) begin
      corr_ctrl <= wdata & ldm_pkg::CORR_CTRL_MASK;
    end
  end

  // Serial output control; resets with the divide-by-2 setting
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ser_ctrl <= ldm_pkg::SERIAL_CTRL_RESET;
    end else if (wr && sel_ser) begin
      ser_ctrl <= wdata & ldm_pkg::SERIAL_CTRL_MASK;
    end
  end

  // Read mux; estimates sampled live so the latest value is returned
  always_comb begin
    next_rdata = ldm_pkg::RESET_ZERO;
    if (hit(addr, ldm_pkg::OVERRANGE_DETECT_CONTROL)) begin
      next_rdata = det_ctrl[chan_sel];
    end else if (hit(addr, ldm_pkg::COARSE_HIGH_LIMIT)) begin
      next_rdata = coarse[chan_sel];
    end else if (hit(addr, ldm_pkg::FINE_HIGH_LIMIT_LOW)) begin
      next_rdata = fine_hi_l[chan_sel];
    end else if (hit(addr, ldm_pkg::FINE_HIGH_LIMIT_HIGH)) begin
      next_rdata = fine_hi_h[chan_sel];
    end else if (hit(addr, ldm_pkg::FINE_LOW_LIMIT_LOW)) begin
      next_rdata = fine_lo_l[chan_sel];
    end else if (hit(addr, ldm_pkg::FINE_LOW_LIMIT_HIGH)) begin
      next_rdata = fine_lo_h[chan_sel];
    end else if (hit(addr, ldm_pkg::GAIN_UP_DWELL_LOW)) begin
      next_rdata = dwell_l[chan_sel];
    end else if (hit(addr, ldm_pkg::GAIN_UP_DWELL_HIGH)) begin
      next_rdata = dwell_h[chan_sel];
    end else if (hit(addr, ldm_pkg::OFFSET_CORRECTION_CONTROL)) begin
      next_rdata = corr_ctrl;
    end else if (sel_dca_l) begin
      next_rdata = dc_est_a[7:0];
    end else if (sel_dca_h) begin
      next_rdata = {2'b00, dc_est_a[13:8]};
    end else if (sel_dcb_l) begin
      next_rdata = dc_est_b[7:0];
    end else if (sel_dcb_h) begin
      next_rdata = {2'b00, dc_est_b[13:8]};
    end else if (hit(addr, ldm_pkg::MONITOR_SERIAL_OUT_CONTROL)) begin
      next_rdata = ser_ctrl;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= ldm_pkg::RESET_ZERO;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= ldm_pkg::RESET_ZERO;
    end
  end

  // Registered detect settings for the datapath, {B, A}
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      detect_enable <= '0;
      detect_mode <= '0;
      coarse_limit <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        detect_enable[i] <= det_ctrl[i][ldm_pkg::DET_EN_BIT];
        detect_mode[i*3 +: 3] <= det_ctrl[i][ldm_pkg::DET_MODE_LSB +: 3];
        coarse_limit[i*3 +: 3] <= coarse[i][2:0];
      end
    end
  end

  // Registered limits and dwell; bytes joined, no atomic update
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fine_high_limit <= '0;
      fine_low_limit <= '0;
      gain_up_dwell <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        fine_high_limit[i*13 +: 13] <= {fine_hi_h[i][4:0], fine_hi_l[i]};
        fine_low_limit[i*13 +: 13] <= {fine_lo_h[i][4:0], fine_lo_l[i]};
        gain_up_dwell[i*16 +: 16] <= {dwell_h[i], dwell_l[i]};
      end
    end
  end

  // Registered global control outputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      corr_bandwidth <= '0;
      corr_path_enable <= 1'b0;
      corr_monitor_enable <= 1'b0;
      corr_freeze <= 1'b0;
    end else begin
      corr_bandwidth <= corr_ctrl[ldm_pkg::CORR_BW_LSB +: 4];
      corr_path_enable <= corr_ctrl[ldm_pkg::CORR_PATH_EN_BIT];
      corr_monitor_enable <= corr_ctrl[ldm_pkg::CORR_MON_EN_BIT];
      corr_freeze <= corr_ctrl[ldm_pkg::CORR_FREEZE_BIT];
    end
  end

  // Registered serial output controls
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      serial_out_enable <= 1'b0;
      serial_clock_sleep <= 1'b0;
      serial_clock_div <= 2'b01;
      serial_thresh_enable <= 1'b0;
      serial_peak_enable <= 1'b0;
      serial_rms_enable <= 1'b0;
    end else begin
      serial_out_enable <= ser_ctrl[ldm_pkg::SER_OUT_EN_BIT];
      serial_clock_sleep <= ser_ctrl[ldm_pkg::SER_SLEEP_BIT];
      serial_clock_div <= ser_ctrl[ldm_pkg::SER_DIV_LSB +: 2];
      serial_thresh_enable <= ser_ctrl[ldm_pkg::SER_THR_EN_BIT];
      serial_peak_enable <= ser_ctrl[ldm_pkg::SER_PEAK_EN_BIT];
      serial_rms_enable <= ser_ctrl[ldm_pkg::SER_RMS_EN_BIT];
    end
  end

endmodule

// [verif/ldm_regs_sva.sv]
// Assertion checker for the overrange and DC monitor register bank
`timescale 1ns/10ps
module ldm_regs_sva #(
  parameter int ADDR_W = 10,
  parameter int DC_W = 14
) (
  // Clock, reset and register port
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic chan_sel,
  input wire logic [7:0] rdata,
  // Estimates and controls
  input wire logic [DC_W-1:0] dc_est_a,
  input wire logic [DC_W-1:0] dc_est_b,
  input wire logic [31:0] gain_up_dwell,
  input wire logic [3:0] corr_bandwidth
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Register lands one edge after the write, output one edge later
  a_dwell_reset: assert property ($rose(rstn) |-> gain_up_dwell == 0)
    else $error("dwell not zero after reset");
  a_dwell_write: assert property (wr && addr == 10'h10a && !chan_sel ##1
    !(wr && addr == 10'h10a) |=> gain_up_dwell[7:0] == $past(wdata, 2))
    else $error("dwell low byte not taken");
  a_dca_low: assert property (rd && addr == 10'h10d |=>
    rdata == $past(dc_est_a[7:0])) else $error("channel A low byte wrong");
  a_dcb_low: assert property (rd && addr == 10'h10f |=>
    rdata == $past(dc_est_b[7:0])) else $error("channel B low byte wrong");
  a_dca_high: assert property (rd && addr == 10'h10e |=>
    rdata == {2'b00, $past(dc_est_a[13:8])}) else $error("A high wrong");
  a_dcb_high: assert property (rd && addr == 10'h110 |=>
    rdata == {2'b00, $past(dc_est_b[13:8])}) else $error("B high wrong");
  a_corr_reset: assert property ($rose(rstn) |-> corr_bandwidth == 0)
    else $error("bandwidth not zero after reset");
  a_corr_write: assert property (wr && addr == 10'h10c ##1
    !(wr && addr == 10'h10c) |=> corr_bandwidth == $past(wdata[5:2], 2))
    else $error("bandwidth not taken");
endmodule
bind ldm_regs ldm_regs_sva #(.ADDR_W(ADDR_W), .DC_W(DC_W)) i_ldm_regs_sva (
  .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .chan_sel(chan_sel), .rdata(rdata), .dc_est_a(dc_est_a),
  .dc_est_b(dc_est_b), .gain_up_dwell(gain_up_dwell),
  .corr_bandwidth(corr_bandwidth));

// [verif/ldm_dc_source.sv]
// Behavioural monitor datapath that supplies both DC estimates
`timescale 1ns/10ps
module ldm_dc_source (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // New estimate, channel B gets its inverse
  input wire logic load,
  input wire logic [13:0] val,
  output logic [13:0] dc_est_a,
  output logic [13:0] dc_est_b
);
  // Estimates move only on load, like a slow correction loop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dc_est_a <= 14'h0000;
      dc_est_b <= 14'h0000;
    end else if (load) begin
      dc_est_a <= val;
      dc_est_b <= ~val;
    end
  end
endmodule

// [verif/ldm_regs_tb.sv]
// Self-checking bench for the overrange and DC monitor register bank
`timescale 1ns/10ps
module ldm_regs_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic chan_sel = 1'b0;
  logic load = 1'b0;
  logic [13:0] val = 14'h0000;
  logic [13:0] dc_est_a;
  logic [13:0] dc_est_b;
  logic [7:0] rdata;
  logic [31:0] gain_up_dwell;
  logic [3:0] corr_bandwidth;
  logic corr_path_enable;
  logic corr_monitor_enable;
  logic corr_freeze;
  logic [1:0] serial_clock_div;
  logic [1:0] detect_enable;
  logic [5:0] detect_mode;
  logic [5:0] coarse_limit;
  logic [25:0] fine_high_limit;
  logic [25:0] fine_low_limit;
  logic serial_out_enable;
  logic serial_clock_sleep;
  logic serial_thresh_enable;
  logic serial_peak_enable;
  logic serial_rms_enable;
  int err_total = 0;
  int samples_checked = 0;
  ldm_regs i_ldm_regs (.clock(clock), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .chan_sel(chan_sel), .rdata(rdata),
    .dc_est_a(dc_est_a), .dc_est_b(dc_est_b),
    .detect_enable(detect_enable), .detect_mode(detect_mode),
    .coarse_limit(coarse_limit), .fine_high_limit(fine_high_limit),
    .fine_low_limit(fine_low_limit),
    .gain_up_dwell(gain_up_dwell), .corr_bandwidth(corr_bandwidth),
    .corr_path_enable(corr_path_enable),
    .corr_monitor_enable(corr_monitor_enable), .corr_freeze(corr_freeze),
    .serial_out_enable(serial_out_enable),
    .serial_clock_sleep(serial_clock_sleep),
    .serial_clock_div(serial_clock_div),
    .serial_thresh_enable(serial_thresh_enable),
    .serial_peak_enable(serial_peak_enable),
    .serial_rms_enable(serial_rms_enable));
  ldm_dc_source i_ldm_dc_source (.clock(clock), .rstn(rstn), .load(load),
    .val(val), .dc_est_a(dc_est_a), .dc_est_b(dc_est_b));
  initial begin
    forever #2.5 clock = ~clock;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // Outputs trail the register by one edge
  task automatic settle;
    @(posedge clock);
    #1;
  endtask
  task automatic test_reset;
    rd_reg(10'h10b, 8'h00);
    rd_reg(10'h10c, 8'h00);
    rd_reg(10'h111, 8'h04);
    chk(serial_clock_div, 32'h0000_0001);
    wr_reg(10'h11f, 8'hff);
    rd_reg(10'h11f, 8'h00);
  endtask
  task automatic test_dwell;
    chan_sel <= 1'b1;
    wr_reg(10'h10a, 8'h5a);
    wr_reg(10'h10b, 8'hff);
    chan_sel <= 1'b0;
    wr_reg(10'h10a, 8'h01);
    settle;
    chk(gain_up_dwell, 32'hff5a_0001);
    rd_reg(10'h10b, 8'h00);
  endtask
  // Bit 7 is open and must read zero
  task automatic test_corr;
    wr_reg(10'h10c, 8'hff);
    settle;
    chk({corr_freeze, corr_bandwidth, corr_monitor_enable,
      corr_path_enable}, 32'h0000_007f);
    rd_reg(10'h10c, 8'h7f);
    wr_reg(10'h10c, 8'h28);
    settle;
    chk(corr_bandwidth, 32'h0000_000a);
  endtask
  // Local settings per channel and serial controls, open bits masked
  task automatic test_local;
    chan_sel <= 1'b0;
    wr_reg(10'h104, 8'hff);
    wr_reg(10'h105, 8'hff);
    wr_reg(10'h106, 8'hab);
    wr_reg(10'h107, 8'hff);
    wr_reg(10'h108, 8'h12);
    wr_reg(10'h109, 8'he3);
    chan_sel <= 1'b1;
    wr_reg(10'h104, 8'h02);
    wr_reg(10'h105, 8'h05);
    wr_reg(10'h111, 8'hff);
    settle;
    chk(detect_enable, 32'h0000_0001);
    chk(detect_mode, 32'h0000_000f);
    chk(coarse_limit, 32'h0000_002f);
    chk(fine_high_limit, 32'h0000_1fab);
    chk(fine_low_limit, 32'h0000_0312);
    chk({serial_rms_enable, serial_peak_enable, serial_thresh_enable,
      serial_clock_div, serial_clock_sleep, serial_out_enable},
      32'h0000_007f);
    rd_reg(10'h104, 8'h02);
    rd_reg(10'h105, 8'h05);
    rd_reg(10'h111, 8'h7f);
    chan_sel <= 1'b0;
  endtask
  // Writes to the estimates are dropped, reads follow the source
  task automatic test_dc(input logic [13:0] a);
    @(posedge clock);
    load <= 1'b1;
    val <= a;
    @(posedge clock);
    load <= 1'b0;
    wr_reg(10'h10d, ~a[7:0]);
    wr_reg(10'h110, 8'hff);
    rd_reg(10'h10d, a[7:0]);
    rd_reg(10'h10e, {2'b00, a[13:8]});
    rd_reg(10'h10f, ~a[7:0]);
    rd_reg(10'h110, {2'b00, ~a[13:8]});
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    test_reset;
    test_dwell;
    test_corr;
    test_local;
    test_dc(14'h3fc0);
    test_dc(14'h1234);
    end_of_test;
  end
endmodule
